// [hdl/dso_pkg.sv]
// constants, register map and carrier types of the drive status output selector
// Contract
// R1: open-collector and relay outputs each pick one status item; codes 0-19, defaults 12, 17.
// R2: detection bandwidth is a frequency in hertz, up to 400, default 10.00.
// R3: code 2 asserts while |detect level - run frequency| <= bandwidth/2.
// R4: code 3 sets at run frequency >= level, holds while above level - bandwidth/2.
// R5: code 4 is the inverse of the code 3 hysteresis condition.
// R6: level and bandwidth 0-400, defaults 30.00, 10.00; values above max frequency refused.
// R7: code 8 follows the over-voltage trip flag.
// R8: code 9 follows the under-voltage trip flag.
// R9: code 10 follows the heatsink overtemperature flag.
// R10: code 11 asserts on loss of analog voltage, analog current or RS485 command.
// R11: code 12 asserts while run command present and output voltage produced.
// R12: code 13 asserts while stopped with no run command.
// R13: code 14 asserts at constant speed, neither accelerating nor decelerating.
// R14: code 16 asserts in normal operation while waiting for a run command.
// R15: code 17 follows the trip mask; mask 2 means any trip except under-voltage.
// R16: code 18 asserts on fan trip when fan-trip policy is 0.
// R17: code 19 outputs the brake control signal when external brake use is enabled.
// R18: keypad error selector 0-3, default 0; bit 0 open collector, bit 1 relay.
// R19: keypad link error declared only after continuous failure for a fixed timeout.
// R20: thermal protection enabled only when its select equals 1; range 0-1, default 0.
// R21: when enabled, output turns off after inverse-time delay above one-minute level.
// R22: one-minute level 50-200 percent, default 150, never below continuous level.
// R23: continuous level 50-150 percent, default 100, never above one-minute level.
// R24: motor type 0 shaft-fan motor, 1 separately cooled; affects low-speed derating.
// R25: codes 5, 6, 7, 15 taken directly from overload, drive overload, stall, search flags.
// R26: both outputs registered on the clock and inactive after reset.
package dso_pkg;

  // register indices on the plain port
  localparam logic [3:0] ADDR_LEVEL     = 4'h0;
  localparam logic [3:0] ADDR_BANDWIDTH = 4'h1;
  localparam logic [3:0] ADDR_MAXFREQ   = 4'h2;
  localparam logic [3:0] ADDR_OCSEL     = 4'h3;
  localparam logic [3:0] ADDR_RELAYSEL  = 4'h4;
  localparam logic [3:0] ADDR_TRIPMASK  = 4'h5;
  localparam logic [3:0] ADDR_KEYPADSEL = 4'h6;
  localparam logic [3:0] ADDR_THERMCTL  = 4'h7;
  localparam logic [3:0] ADDR_ONEMIN    = 4'h8;
  localparam logic [3:0] ADDR_CONT      = 4'h9;
  localparam logic [3:0] ADDR_STATUS    = 4'hA;
  localparam logic [3:0] ADDR_THERMACC  = 4'hB;

  // thermal control field positions
  localparam int THERMCTL_ENABLE_BIT = 0;
  localparam int THERMCTL_MOTOR_BIT  = 1;
  localparam int THERMCTL_FAN_BIT    = 2;
  localparam int THERMCTL_BRAKE_BIT  = 3;

  // frequencies in units of 0.01 Hz
  localparam logic [15:0] FREQ_LIMIT       = 16'h9C40;  // 400.00 Hz
  localparam logic [15:0] RST_LEVEL        = 16'h0BB8;  // 30.00 Hz
  localparam logic [15:0] RST_BANDWIDTH    = 16'h03E8;  // 10.00 Hz
  localparam logic [15:0] RST_MAXFREQ      = 16'h1770;  // 60.00 Hz
  localparam logic [15:0] LOW_SPEED_FREQ   = 16'h07D0;  // 20.00 Hz derating knee

  localparam logic [4:0]  SEL_MAX          = 5'h13;     // code 19
  localparam logic [4:0]  RST_OCSEL        = 5'h0C;     // code 12
  localparam logic [4:0]  RST_RELAYSEL     = 5'h11;     // code 17
  localparam logic [2:0]  RST_TRIPMASK     = 3'h2;
  localparam logic [1:0]  RST_KEYPADSEL    = 2'h0;
  localparam logic [3:0]  RST_THERMCTL     = 4'h0;

  localparam logic [7:0]  ONEMIN_MIN       = 8'h32;     // 50 %
  localparam logic [7:0]  ONEMIN_MAX       = 8'hC8;     // 200 %
  localparam logic [7:0]  CONT_MIN         = 8'h32;     // 50 %
  localparam logic [7:0]  CONT_MAX         = 8'h96;     // 150 %
  localparam logic [7:0]  RST_ONEMIN       = 8'h96;     // 150 %
  localparam logic [7:0]  RST_CONT         = 8'h64;     // 100 %

  // timing
  localparam int CLOCK_HZ          = 40_000_000;
  localparam int KEYPAD_TIMEOUT_MS = 100;
  localparam int KEYPAD_TIMEOUT_CYC = KEYPAD_TIMEOUT_MS * (CLOCK_HZ / 1000);
  localparam int THERM_TICK_MS     = 1;
  localparam int THERM_TICK_CYC    = THERM_TICK_MS * (CLOCK_HZ / 1000);
  localparam int THERM_WINDOW_S    = 60;
  localparam int THERM_WINDOW_TICKS = THERM_WINDOW_S * 1000 / THERM_TICK_MS;

  typedef struct packed {
    logic [15:0] detectLevel;
    logic [15:0] detectBandwidth;
    logic [15:0] maxFreq;
    logic [4:0]  ocSelect;
    logic [4:0]  relaySelect;
    logic [2:0]  tripMask;
    logic [1:0]  keypadSelect;
    logic [3:0]  thermCtl;
    logic [7:0]  oneMinLevel;
    logic [7:0]  contLevel;
  } dso_cfg_t;

  // drive state and fault flags from neighbouring blocks
  typedef struct packed {
    logic [15:0] runFreq;
    logic [15:0] setFreq;
    logic [9:0]  motorCurrentPct;
    logic        accelerating;
    logic        decelerating;
    logic        runCmd;
    logic        outputActive;
    logic        stopped;
    logic        waitRunCmd;
    logic        overload;
    logic        driveOverload;
    logic        stall;
    logic        speedSearch;
    logic        overVoltTrip;
    logic        underVoltTrip;
    logic        otherTrip;
    logic        autoRestart;
    logic        heatsinkOvertemp;
    logic        voltageRefLoss;
    logic        currentRefLoss;
    logic        rs485Loss;
    logic        fanTrip;
    logic        brakeCtrl;
    logic        keypadCommOk;
  } dso_drive_t;

endpackage

// [hdl/dso_selector.sv]
// status output selector with frequency detect, keypad link watch and motor thermal model
`timescale 1ns/1ps
module dso_selector #(
  parameter int KEYPAD_TIMEOUT = dso_pkg::KEYPAD_TIMEOUT_CYC,
  parameter int THERM_TICK     = dso_pkg::THERM_TICK_CYC
) (
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // register port
  input  wire logic [3:0]        regAddr,
  input  wire logic [31:0]       regWdata,
  input  wire logic              regWrite,
  input  wire logic              regRead,
  output logic      [31:0]       regRdata,
  // drive state
  input  wire dso_pkg::dso_drive_t drive,
  // physical outputs
  output logic                   openCollectorOutput,
  output logic                   relayOutput,
  output logic                   keypadErrorDisplay,
  output logic                   thermalShutoff
);
  import dso_pkg::*;

  typedef struct packed {
    dso_cfg_t    cfg;
    logic [31:0] rdata;
    logic        hyst;
    logic        ocOut;
    logic        relayOut;
    logic [31:0] keypadCount;
    logic        keypadErr;
    logic [31:0] tickCount;
    logic [23:0] thermAcc;
    logic        thermTrip;
  } dso_state_t;

  dso_state_t st;
  dso_state_t next_st;

  // detection terms
  logic [15:0] halfBand;
  logic [15:0] levelDiff;
  logic [15:0] setDiff;
  logic        windowDetect;
  logic        setWindowDetect;
  logic        levelHysteresisDetect;
  logic        faultOutput;
  logic [19:0] items;
  // write decode
  logic [15:0] wFreq;
  logic [7:0]  wPct;
  logic        freqOk;
  // thermal terms
  logic [7:0]  effCont;
  logic [9:0]  contWide;
  logic [23:0] tripLimit;
  logic [23:0] excess;
  logic [23:0] relief;
  logic        tick;
  logic        thermEnable;

  function automatic logic pick(input logic [4:0] code, input logic [19:0] vec);
    logic r;
    r = 1'b0;
    if (code <= SEL_MAX) begin
      r = vec[code];
    end
    return r;
  endfunction

  always_comb begin
    halfBand  = {1'b0, st.cfg.detectBandwidth[15:1]};
    levelDiff = (st.cfg.detectLevel >= drive.runFreq) ?
                16'(st.cfg.detectLevel - drive.runFreq) :
                16'(drive.runFreq - st.cfg.detectLevel);
    setDiff   = (drive.setFreq >= drive.runFreq) ?
                16'(drive.setFreq - drive.runFreq) :
                16'(drive.runFreq - drive.setFreq);
    setWindowDetect = (setDiff <= halfBand);
    windowDetect    = (levelDiff <= halfBand);                       // see R3
    levelHysteresisDetect = st.hyst;
    faultOutput = (st.cfg.tripMask[0] & drive.underVoltTrip) |      // see R15
                  (st.cfg.tripMask[1] & drive.otherTrip) |
                  (st.cfg.tripMask[2] & drive.autoRestart);

    items[0]  = setWindowDetect;
    items[1]  = setWindowDetect & (drive.setFreq == st.cfg.detectLevel);
    items[2]  = windowDetect;                                       // see R3
    items[3]  = levelHysteresisDetect;                              // see R4
    items[4]  = ~levelHysteresisDetect;                             // see R5
    items[5]  = drive.overload;                                     // see R25
    items[6]  = drive.driveOverload;                                // see R25
    items[7]  = drive.stall;                                        // see R25
    items[8]  = drive.overVoltTrip;                                 // see R7
    items[9]  = drive.underVoltTrip;                                // see R8
    items[10] = drive.heatsinkOvertemp;                             // see R9
    items[11] = drive.voltageRefLoss | drive.currentRefLoss |       // see R10
                drive.rs485Loss;
    items[12] = drive.runCmd & drive.outputActive;                  // see R11
    items[13] = drive.stopped & ~drive.runCmd;                      // see R12
    items[14] = drive.outputActive & ~drive.accelerating &          // see R13
                ~drive.decelerating;
    items[15] = drive.speedSearch;                                  // see R25
    items[16] = drive.waitRunCmd;                                   // see R14
    items[17] = faultOutput;                                        // see R15
    items[18] = drive.fanTrip & ~st.cfg.thermCtl[THERMCTL_FAN_BIT]; // see R16
    items[19] = drive.brakeCtrl & st.cfg.thermCtl[THERMCTL_BRAKE_BIT]; // see R17
  end

  // thermal model terms
  always_comb begin
    thermEnable = st.cfg.thermCtl[THERMCTL_ENABLE_BIT];              // see R20
    tick        = (st.tickCount == 32'(THERM_TICK - 1));
    // shaft-fan motor loses cooling at low speed
    if (!st.cfg.thermCtl[THERMCTL_MOTOR_BIT] && drive.runFreq < LOW_SPEED_FREQ) begin
      effCont = 8'(st.cfg.contLevel - {2'b00, st.cfg.contLevel[7:2]}); // see R24
    end else begin
      effCont = st.cfg.contLevel;
    end
    contWide  = {2'b00, effCont};
    tripLimit = 24'((st.cfg.oneMinLevel - effCont) * THERM_WINDOW_TICKS);
    if (drive.motorCurrentPct > contWide) begin
      excess = 24'(drive.motorCurrentPct - contWide);
      relief = 24'h00_0000;
    end else begin
      excess = 24'h00_0000;
      relief = 24'(contWide - drive.motorCurrentPct);
    end
  end

  // write value checks
  always_comb begin
    wFreq  = regWdata[15:0];
    wPct   = regWdata[7:0];
    freqOk = (regWdata[31:16] == 16'h0000) && (wFreq <= FREQ_LIMIT) &&
             (wFreq <= st.cfg.maxFreq);                              // see R6
  end

  always_comb begin
    next_st = st;

    // register writes, out-of-range values are ignored; trip mask, keypad select and thermal control take the low bits
    if (regWrite) begin
      case (regAddr)
        ADDR_LEVEL: begin
          if (freqOk) begin
            next_st.cfg.detectLevel = wFreq;                         // see R6
          end
        end
        ADDR_BANDWIDTH: begin
          if (freqOk) begin
            next_st.cfg.detectBandwidth = wFreq;                     // see R2
          end
        end
        ADDR_MAXFREQ: begin
          if (regWdata[31:16] == 16'h0000 && wFreq <= FREQ_LIMIT &&
              wFreq >= st.cfg.detectLevel && wFreq >= st.cfg.detectBandwidth) begin
            next_st.cfg.maxFreq = wFreq;
          end
        end
        ADDR_OCSEL: begin
          if (regWdata[31:5] == 27'h000_0000 && regWdata[4:0] <= SEL_MAX) begin
            next_st.cfg.ocSelect = regWdata[4:0];                    // see R1
          end
        end
        ADDR_RELAYSEL: begin
          if (regWdata[31:5] == 27'h000_0000 && regWdata[4:0] <= SEL_MAX) begin
            next_st.cfg.relaySelect = regWdata[4:0];                 // see R1
          end
        end
        ADDR_TRIPMASK: begin
          next_st.cfg.tripMask = regWdata[2:0];
        end
        ADDR_KEYPADSEL: begin
          next_st.cfg.keypadSelect = regWdata[1:0];                  // see R18
        end
        ADDR_THERMCTL: begin
          next_st.cfg.thermCtl = regWdata[3:0];                      // see R20
        end
        ADDR_ONEMIN: begin
          if (regWdata[31:8] == 24'h00_0000 && wPct >= ONEMIN_MIN &&
              wPct <= ONEMIN_MAX && wPct >= st.cfg.contLevel) begin  // see R22
            next_st.cfg.oneMinLevel = wPct;
          end
        end
        ADDR_CONT: begin
          if (regWdata[31:8] == 24'h00_0000 && wPct >= CONT_MIN &&
              wPct <= CONT_MAX && wPct <= st.cfg.oneMinLevel) begin  // see R23
            next_st.cfg.contLevel = wPct;
          end
        end
        default: begin
        end
      endcase
    end

    // register reads, data in the following cycle only
    next_st.rdata = 32'h0000_0000;
    if (regRead) begin
      case (regAddr)
        ADDR_LEVEL:     next_st.rdata = {16'h0000, st.cfg.detectLevel};
        ADDR_BANDWIDTH: next_st.rdata = {16'h0000, st.cfg.detectBandwidth};
        ADDR_MAXFREQ:   next_st.rdata = {16'h0000, st.cfg.maxFreq};
        ADDR_OCSEL:     next_st.rdata = {27'h000_0000, st.cfg.ocSelect};
        ADDR_RELAYSEL:  next_st.rdata = {27'h000_0000, st.cfg.relaySelect};
        ADDR_TRIPMASK:  next_st.rdata = {29'h0000_0000, st.cfg.tripMask};
        ADDR_KEYPADSEL: next_st.rdata = {30'h0000_0000, st.cfg.keypadSelect};
        ADDR_THERMCTL:  next_st.rdata = {28'h000_0000, st.cfg.thermCtl};
        ADDR_ONEMIN:    next_st.rdata = {24'h00_0000, st.cfg.oneMinLevel};
        ADDR_CONT:      next_st.rdata = {24'h00_0000, st.cfg.contLevel};
        ADDR_STATUS:    next_st.rdata = {26'h000_0000, st.thermTrip, st.keypadErr,
                                         windowDetect, st.hyst, st.relayOut, st.ocOut};
        ADDR_THERMACC:  next_st.rdata = {8'h00, st.thermAcc};
        default:        next_st.rdata = 32'h0000_0000;
      endcase
    end

    // level hysteresis: set at level, hold above level minus half band
    if (drive.runFreq >= st.cfg.detectLevel) begin
      next_st.hyst = 1'b1;                                           // see R4
    end else if ({1'b0, drive.runFreq} + {1'b0, halfBand} > {1'b0, st.cfg.detectLevel}) begin
      next_st.hyst = st.hyst;                                        // see R4
    end else begin
      next_st.hyst = 1'b0;
    end

    // keypad link watchdog
    if (drive.keypadCommOk) begin
      next_st.keypadCount = 32'h0000_0000;
      next_st.keypadErr   = 1'b0;
    end else if (st.keypadCount >= 32'(KEYPAD_TIMEOUT - 1)) begin
      next_st.keypadErr   = 1'b1;                                    // see R19
    end else begin
      next_st.keypadCount = st.keypadCount + 32'h0000_0001;
    end

    // registered outputs with keypad error routing
    next_st.ocOut    = pick(st.cfg.ocSelect, items) |                // see R26
                       (st.keypadErr & st.cfg.keypadSelect[0]);      // see R18
    next_st.relayOut = pick(st.cfg.relaySelect, items) |             // see R26
                       (st.keypadErr & st.cfg.keypadSelect[1]);      // see R18

    // thermal tick divider
    if (tick) begin
      next_st.tickCount = 32'h0000_0000;
    end else begin
      next_st.tickCount = st.tickCount + 32'h0000_0001;
    end

    // inverse-time integrator
    if (!thermEnable) begin
      next_st.thermAcc  = 24'h00_0000;
      next_st.thermTrip = 1'b0;                                      // see R20
    end else if (tick) begin
      if (excess != 24'h00_0000) begin
        if (st.thermAcc > 24'hFF_FFFF - excess) begin
          next_st.thermAcc = 24'hFF_FFFF;
        end else begin
          next_st.thermAcc = st.thermAcc + excess;
        end
      end else if (st.thermAcc > relief) begin
        next_st.thermAcc = st.thermAcc - relief;
      end else begin
        next_st.thermAcc = 24'h00_0000;
      end
      if (st.thermAcc >= tripLimit) begin
        next_st.thermTrip = 1'b1;                                    // see R21
      end else if (st.thermAcc == 24'h00_0000) begin
        next_st.thermTrip = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st.cfg.detectLevel     <= RST_LEVEL;                           // see R6
      st.cfg.detectBandwidth <= RST_BANDWIDTH;                       // see R2
      st.cfg.maxFreq         <= RST_MAXFREQ;
      st.cfg.ocSelect        <= RST_OCSEL;                           // see R1
      st.cfg.relaySelect     <= RST_RELAYSEL;                        // see R1
      st.cfg.tripMask        <= RST_TRIPMASK;
      st.cfg.keypadSelect    <= RST_KEYPADSEL;                       // see R18
      st.cfg.thermCtl        <= RST_THERMCTL;                        // see R20
      st.cfg.oneMinLevel     <= RST_ONEMIN;                          // see R22
      st.cfg.contLevel       <= RST_CONT;                            // see R23
      st.rdata               <= 32'h0000_0000;
      st.hyst                <= 1'b0;
      st.ocOut               <= 1'b0;                                // see R26
      st.relayOut            <= 1'b0;                                // see R26
      st.keypadCount         <= 32'h0000_0000;
      st.keypadErr           <= 1'b0;
      st.tickCount           <= 32'h0000_0000;
      st.thermAcc            <= 24'h00_0000;
      st.thermTrip           <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign regRdata            = st.rdata;
  assign openCollectorOutput = st.ocOut;
  assign relayOutput         = st.relayOut;
  assign keypadErrorDisplay  = st.keypadErr;
  assign thermalShutoff      = st.thermTrip;

endmodule // dso_selector

// [testbench/dso_selector_monitor.sv]
// port checker for the drive status output selector
`timescale 1ns/1ps
module dso_selector_monitor #(
  parameter int KEYPAD_TIMEOUT = 16
) (
  // clock and reset
  input wire logic                clock,
  input wire logic                rst_n,
  // register port
  input wire logic [3:0]          regAddr,
  input wire logic [31:0]         regWdata,
  input wire logic                regWrite,
  input wire logic                regRead,
  input wire logic [31:0]         regRdata,
  // drive state and outputs
  input wire dso_pkg::dso_drive_t drive,
  input wire logic                openCollectorOutput,
  input wire logic                relayOutput,
  input wire logic                keypadErrorDisplay,
  input wire logic                thermalShutoff
);
  import dso_pkg::*;
  logic [4:0]  ocSel;
  logic [4:0]  rlySel;
  logic        thermEn;
  logic [31:0] lowCnt;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ocSel <= RST_OCSEL;
      rlySel <= RST_RELAYSEL;
      thermEn <= 1'b0;
      lowCnt <= 32'h0000_0000;
    end else begin
      lowCnt <= drive.keypadCommOk ? 32'h0000_0000 : lowCnt + 32'h0000_0001;
      if (regWrite && regAddr == ADDR_OCSEL && regWdata <= 32'(SEL_MAX)) begin
        ocSel <= regWdata[4:0];
      end
      if (regWrite && regAddr == ADDR_RELAYSEL && regWdata <= 32'(SEL_MAX)) begin
        rlySel <= regWdata[4:0];
      end
      if (regWrite && regAddr == ADDR_THERMCTL) begin
        thermEn <= regWdata[THERMCTL_ENABLE_BIT];
      end
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  reset_quiet_a: assert property ($rose(rst_n) |-> !openCollectorOutput && !relayOutput)
    else $error("output active out of reset");
  read_idle_a: assert property (!regRead |=> regRdata == 32'h0000_0000)
    else $error("read data without read");
  unmapped_read_a: assert property (regRead && regAddr > ADDR_THERMACC |=> regRdata == 32'h0)
    else $error("unmapped read not zero");
  keypad_clear_a: assert property (drive.keypadCommOk |=> !keypadErrorDisplay)
    else $error("keypad error kept");
  keypad_early_a: assert property ($rose(keypadErrorDisplay) |-> lowCnt + 2 >= KEYPAD_TIMEOUT)
    else $error("keypad error too early");
  keypad_late_a: assert property (lowCnt == KEYPAD_TIMEOUT + 3 |-> keypadErrorDisplay)
    else $error("keypad error too late");
  therm_off_a: assert property (!thermEn [*2] |-> !thermalShutoff)
    else $error("thermal trip while disabled");
  run_on_a: assert property (ocSel == 5'h0C && drive.runCmd && drive.outputActive |=> openCollectorOutput)
    else $error("run status missing");
  run_off_a: assert property (ocSel == 5'h0C && !drive.runCmd && !keypadErrorDisplay
    && !$past(keypadErrorDisplay) |=> !openCollectorOutput)
    else $error("run status without run");
  overvolt_relay_a: assert property (rlySel == 5'h08 && drive.overVoltTrip |=> relayOutput)
    else $error("overvoltage not on relay");
endmodule // dso_selector_monitor

bind dso_selector dso_selector_monitor #(.KEYPAD_TIMEOUT(KEYPAD_TIMEOUT)) dso_selector_monitor_i (
  .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
  .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .drive(drive),
  .openCollectorOutput(openCollectorOutput), .relayOutput(relayOutput),
  .keypadErrorDisplay(keypadErrorDisplay), .thermalShutoff(thermalShutoff));

// [testbench/dso_ext_sequence.sv]
// external control sequence giving the run command, with a fault interlock
`timescale 1ns/1ps
module dso_ext_sequence (
  // clock, reset and requests
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic startReq,
  input  wire logic interlock,
  // contacts
  input  wire logic relayOutput,
  output logic      runCmd
);
  logic tripped;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tripped <= 1'b0;
    end else begin
      tripped <= interlock & relayOutput;
    end
  end
  assign runCmd = startReq & !tripped;
endmodule // dso_ext_sequence

// [testbench/dso_selector_test.sv]
// self-checking bench for the drive status output selector
`timescale 1ns/1ps
module dso_selector_test;
  import dso_pkg::*;
  localparam int KP_T = 16;
  logic [3:0]  regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0000_0000;
  logic [31:0] regRdata;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic        regWrite = 1'b0;
  logic        regRead = 1'b0;
  logic        startReq = 1'b0;
  logic        interlock = 1'b0;
  logic        oc, rly, kpErr, thOff, seqRun;
  dso_drive_t  drv = '0;
  dso_drive_t  drvIn;
  int          seed = 32'he54d_3f82;
  int          nFail = 0;
  int          numChecks = 0;
  always #12.5 clock = ~clock;
  always_comb begin
    drvIn = drv;
    drvIn.runCmd = seqRun;
  end
  dso_selector #(.KEYPAD_TIMEOUT(KP_T), .THERM_TICK(4)) dso_selector_i (
    .clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .drive(drvIn),
    .openCollectorOutput(oc), .relayOutput(rly), .keypadErrorDisplay(kpErr),
    .thermalShutoff(thOff));
  dso_ext_sequence dso_ext_sequence_i (.clock(clock), .rst_n(rst_n), .startReq(startReq),
    .interlock(interlock), .relayOutput(rly), .runCmd(seqRun));
  task automatic closeOut();
    if (nFail == 0 && numChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      nFail++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    tick(1);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    tick(1);
    regRead <= 1'b0;
    d = regRdata;
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] v;
    rd(a, v);
    chk(v, e);
  endtask
  function automatic int expOut(input int c, input dso_drive_t d, input int tm, input int tc);
    case (c)
      0: return (d.setFreq > d.runFreq ? d.setFreq - d.runFreq : d.runFreq - d.setFreq) <= 500;
      1: return d.setFreq == 16'h0BB8 && expOut(0, d, tm, tc);
      5: return d.overload;
      6: return d.driveOverload;
      7: return d.stall;
      8: return d.overVoltTrip;
      9: return d.underVoltTrip;
      10: return d.heatsinkOvertemp;
      11: return d.voltageRefLoss | d.currentRefLoss | d.rs485Loss;
      12: return d.runCmd & d.outputActive;
      13: return d.stopped & !d.runCmd;
      14: return d.outputActive & !d.accelerating & !d.decelerating;
      15: return d.speedSearch;
      16: return d.waitRunCmd;
      17: return (tm[0] & d.underVoltTrip) | (tm[1] & d.otherTrip) | (tm[2] & d.autoRestart);
      18: return d.fanTrip & !tc[2];
      default: return d.brakeCtrl & tc[3];
    endcase
  endfunction
  initial begin
    static logic [15:0] dflt [10] = '{16'h0BB8, 16'h03E8, 16'h1770, 16'h000C, 16'h0011,
                                16'h0002, 16'h0000, 16'h0000, 16'h0096, 16'h0064};
    static int   fq [12] = '{0, 2400, 2500, 2600, 2999, 3000, 3400, 3500, 2600, 2501, 2500, 2000};
    logic [31:0] v0, v1;
    logic [63:0] r;
    dso_drive_t  nd;
    int          h, w, cnt;
    drv.keypadCommOk = 1'b1;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) rc(4'(i), 32'(dflt[i]));
    for (int i = 12; i < 16; i++) rc(4'(i), 32'h0000_0000);
    wr(ADDR_OCSEL, 32'h0000_0014);
    rc(ADDR_OCSEL, 32'h0000_000C);
    wr(ADDR_LEVEL, 32'h0000_1771);
    rc(ADDR_LEVEL, 32'h0000_0BB8);
    wr(ADDR_ONEMIN, 32'h0000_0063);
    rc(ADDR_ONEMIN, 32'h0000_0096);
    wr(ADDR_CONT, 32'h0000_0097);
    rc(ADDR_CONT, 32'h0000_0064);
    for (int c = 0; c < 20; c += (c == 1) ? 4 : 1) begin
      wr(ADDR_OCSEL, 32'(c));
      wr(ADDR_RELAYSEL, 32'(c));
      repeat (6) begin
        r = {$random(seed), $random(seed)};
        wr(ADDR_TRIPMASK, 32'(r[34:32]));
        wr(ADDR_THERMCTL, 32'(r[39:36]) & 32'h0000_000E);
        nd = r[$bits(dso_drive_t)-1:0];
        nd.keypadCommOk = 1'b1;
        nd.motorCurrentPct = 10'h000;
        nd.runFreq = 16'h09C4 + 16'(r[41:32]);
        nd.setFreq = r[42] ? 16'h0BB8 : nd.runFreq;
        drv <= nd;
        startReq <= nd.runCmd;
        tick(2);
        w = expOut(c, drvIn, int'(r[34:32]), int'(r[39:36]));
        chk(32'({oc, rly}), 32'({2{w[0]}}));
      end
    end
    nd = '0;
    nd.keypadCommOk = 1'b1;
    drv <= nd;
    startReq <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      wr(ADDR_OCSEL, p ? 32'h0000_0002 : 32'h0000_0003);
      wr(ADDR_RELAYSEL, 32'h0000_0004);
      foreach (fq[i]) begin
        drv.runFreq <= 16'(fq[i]);
        tick(3);
        h = fq[i] >= 3000 ? 1 : (fq[i] + 500 > 3000 ? h : 0);
        w = (fq[i] >= 2500 && fq[i] <= 3500);
        chk(32'({oc, rly}), 32'({p ? w[0] : h[0], !h[0]}));
      end
    end
    wr(ADDR_OCSEL, 32'h0000_0008);
    wr(ADDR_RELAYSEL, 32'h0000_0008);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_KEYPADSEL, 32'(k));
      drv.keypadCommOk <= 1'b0;
      tick(KP_T - 6);
      chk(32'({kpErr, oc, rly}), 32'h0000_0000);
      tick(12);
      chk(32'({kpErr, oc, rly}), 32'({1'b1, k[0], k[1]}));
      drv.keypadCommOk <= 1'b1;
      tick(3);
      chk(32'({kpErr, oc, rly}), 32'h0000_0000);
    end
    wr(ADDR_ONEMIN, 32'h0000_0065);
    drv.runFreq <= 16'h0BB8;
    drv.motorCurrentPct <= 10'h0C8;
    wr(ADDR_THERMCTL, 32'h0000_0001);
    for (cnt = 0; cnt < 3000 && thOff !== 1'b1; cnt++) tick(1);
    chk(32'(cnt >= 2390 && cnt <= 2410), 32'h0000_0001);
    drv.motorCurrentPct <= 10'h000;
    for (cnt = 0; cnt < 3000 && thOff !== 1'b0; cnt++) tick(1);
    chk(32'(cnt > 2300 && cnt < 2500), 32'h0000_0001);
    drv.runFreq <= 16'h03E8;
    drv.motorCurrentPct <= 10'h064;
    for (int m = 0; m < 2; m++) begin
      wr(ADDR_THERMCTL, 32'(1 + 2 * m));
      rd(ADDR_THERMACC, v0);
      tick(38);
      rd(ADDR_THERMACC, v1);
      chk(v1 - v0, m ? 32'h0000_0000 : 32'h0000_00FA);
    end
    wr(ADDR_THERMCTL, 32'h0000_0000);
    drv.outputActive <= 1'b1;
    startReq <= 1'b1;
    interlock <= 1'b1;
    wr(ADDR_OCSEL, 32'h0000_000C);
    for (int v = 0; v < 3; v++) begin
      drv.overVoltTrip <= (v == 1);
      tick(5);
      chk(32'({oc, rly}), v == 1 ? 32'h0000_0001 : 32'h0000_0002);
    end
    closeOut();
  end
  initial begin
    repeat (60000) @(posedge clock);
    nFail++;
    closeOut();
  end
endmodule // dso_selector_test
